// ===== design/stop_pkg.sv
// Purpose: Shared constants and types for the stop-mode power control.
// Assumes: Single system clock; 12-bit register addresses, 8-bit data.
// Notes:   Every number used by the design files is named here, except the 8'h01, 5'h00, ##16 and WDATA bit index literals in stop_power_ctrl.

package stop_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [11:0] PG_ADDR = 12'hF80;      // Power-gate register
    localparam logic [11:0] CAUSE_ADDR = 12'hF81;   // Reset cause flags
    localparam logic [11:0] CTRL_ADDR = 12'hF82;    // Mode control
    localparam logic [11:0] SRC_EN_ADDR = 12'hF83;  // Pin recovery enables
    localparam logic [11:0] PORT_ADDR = 12'hF84;    // Port input latch
    localparam logic [11:0] ISTAT_ADDR = 12'hF85;   // Interrupt status
    localparam logic [11:0] IMASK_ADDR = 12'hF86;   // Interrupt mask

    // ----------------------------------------------------------------
    // Widths, reset values and field positions
    // ----------------------------------------------------------------
    localparam int PORT_W = 8;                      // GPIO pins watched
    localparam logic [7:0] PG_RESET = 8'hF8;        // Power-on value
    localparam logic [7:0] ZERO8 = 8'h00;           // Cleared byte
    localparam int PG_BOD_BIT = 4;                  // Brown-out disable
    localparam int PG_COMP_BIT = 1;                 // Comparator disable
    localparam int CTRL_STOP_BIT = 0;               // Write 1 enters STOP
    localparam int CTRL_WDT_IRQ_BIT = 1;            // Watchdog irq mode
    localparam int CTRL_IRQ_EN_BIT = 2;             // Core takes irqs
    localparam int EV_REC_BIT = 0;                  // Recovery finished
    localparam int EV_WDT_BIT = 1;                  // Watchdog interrupt
    localparam int EV_PIN_BIT = 2;                  // Latched pin change
    localparam int EV_W = 3;                        // Event count

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;               // MCLK at 250 MHz
    localparam int RECOV_DELAY_NS = 64;             // Recovery delay
    localparam int RECOV_CYCLES =
        (RECOV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] RECOV_LAST = 5'(RECOV_CYCLES - 1);
    localparam logic [4:0] CNT_ZERO = 5'h00;        // Counter start
    localparam logic [4:0] CNT_ONE = 5'h01;         // Counter step

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_STOP = 4'h2,
        ST_RECOVER = 4'h4,
        ST_RESET = 4'h8
    } pm_state_type;

    // Reset cause flags, low two bits used
    typedef struct packed {
        logic [5:0] spare;
        logic wdt;
        logic stop;
    } cause_type;

endpackage

// ===== design/pin_watch.sv
// Purpose: Port input latch with stop-mode freeze and change detection.
// Assumes: Pins synchronous to the clock.
// Notes:   The frozen latch is the reference for change detection.

module pin_watch
    import stop_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic freeze,
    input wire logic capture,
    input wire logic [PORT_W-1:0] pins,
    input wire logic [PORT_W-1:0] enable,
    output logic [PORT_W-1:0] latch_q,
    output logic change,
    output logic persist
);

    // ----------------------------------------------------------------
    // Input latch
    // ----------------------------------------------------------------
    logic [PORT_W-1:0] diff;                        // Pins against latch

    // Samples every cycle, holds while frozen, takes a final sample
    always_ff @(posedge clk) begin
        if (rst) begin
            latch_q <= '0;
        end else if (ce) begin
            if (!freeze || capture) begin
                latch_q <= pins;
            end
        end
    end

    // ----------------------------------------------------------------
    // Change detection
    // ----------------------------------------------------------------
    assign diff = (pins ^ latch_q) & enable;
    // Either edge of an enabled pin wakes the device
    assign change = |diff;
    // Only a level still held at the capture counts as a pin event
    assign persist = |diff;

endmodule

// ===== design/stop_power_ctrl.sv
// Purpose: Stop-mode recovery control, reset causes, peripheral gating.
// Assumes: Synchronous inputs; watchdog timeout is a one-cycle pulse.
// Notes:   POR_RST alone loads PG_RESET into the power-gate register.

module stop_power_ctrl
    import stop_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic POR_RST,
    input wire logic CE,
    input wire logic [11:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic WDT_TIMEOUT,
    input wire logic EXT_RESET_N,
    input wire logic DEBUG_N,
    input wire logic [PORT_W-1:0] GPIO_IN,
    input wire logic BOD_ALWAYS_ON,
    output logic CORE_CLK_EN,
    output logic SYS_RESET_REQ,
    output logic BOD_ENABLE,
    output logic COMP_ENABLE,
    output logic IRQ
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic rst;                                      // Any reset
    pm_state_type state_r;                          // Power state
    pm_state_type state_nxt;                        // Next power state
    logic [4:0] cnt_r;                              // Recovery delay count
    logic wdt_wake_r;                               // Recovery from watchdog
    logic [7:0] pg_r;                               // Power-gate register
    cause_type cause_r;                             // Reset cause flags
    logic [7:0] ctrl_r;                             // Mode control
    logic [PORT_W-1:0] src_en_r;                    // Pin recovery enables
    logic [EV_W-1:0] istat_r;                       // Sticky events
    logic [EV_W-1:0] imask_r;                       // Event mask
    logic [EV_W-1:0] ev_set;                        // Events this cycle
    logic [PORT_W-1:0] port_q;                      // Port latch value
    logic pin_change;                               // Pin woke the device
    logic pin_persist;                              // Change still held
    logic freeze;                                   // Latch frozen
    logic rec_done;                                 // Delay just ended
    logic reset_src;                                // Full reset source
    logic wr_pg;                                    // Power-gate write
    logic wr_ctrl;                                  // Control write

    assign rst = SYS_RST || POR_RST;
    assign freeze = (state_r == ST_STOP) || (state_r == ST_RECOVER);
    assign rec_done = (state_r == ST_RECOVER) && (cnt_r == RECOV_LAST);
    assign reset_src = !EXT_RESET_N || !DEBUG_N;
    assign wr_pg = WR && (ADDR == PG_ADDR);
    assign wr_ctrl = WR && (ADDR == CTRL_ADDR);

    // ----------------------------------------------------------------
    // Port input latch
    // ----------------------------------------------------------------
    pin_watch u_pins (
        .clk(MCLK),
        .rst(rst),
        .ce(CE),
        .freeze(freeze),
        .capture(rec_done),
        .pins(GPIO_IN),
        .enable(src_en_r),
        .latch_q(port_q),
        .change(pin_change),
        .persist(pin_persist)
    );

    // ----------------------------------------------------------------
    // Power state machine
    // ----------------------------------------------------------------
    // Reset sources win over recovery sources
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (wr_ctrl && WDATA[CTRL_STOP_BIT]) begin
                    state_nxt = ST_STOP;
                end
            end
            ST_STOP: begin
                if (reset_src) begin
                    state_nxt = ST_RESET;
                end else if (WDT_TIMEOUT) begin
                    state_nxt = ST_RECOVER;
                end else if (pin_change) begin
                    state_nxt = ST_RECOVER;
                end else begin
                    state_nxt = ST_STOP;
                end
            end
            ST_RECOVER: begin
                if (rec_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RESET: begin
                state_nxt = ST_RESET;               // Wait for SYS_RST
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge MCLK) begin
        if (rst) begin
            state_r <= ST_RUN;
        end else if (CE) begin
            state_r <= state_nxt;
        end
    end

    // Recovery delay counter
    always_ff @(posedge MCLK) begin
        if (rst) begin
            cnt_r <= CNT_ZERO;
        end else if (CE) begin
            if (state_r == ST_RECOVER) begin
                cnt_r <= cnt_r + CNT_ONE;
            end else begin
                cnt_r <= CNT_ZERO;
            end
        end
    end

    // Remember whether the watchdog caused this recovery
    always_ff @(posedge MCLK) begin
        if (rst) begin
            wdt_wake_r <= 1'b0;
        end else if (CE) begin
            if (state_r == ST_STOP) begin
                wdt_wake_r <= WDT_TIMEOUT;
            end
        end
    end

    // ----------------------------------------------------------------
    // Power-gate register
    // ----------------------------------------------------------------
    // Only power-on reset loads it with PG_RESET; reserved bits stay writable
    always_ff @(posedge MCLK) begin
        if (POR_RST) begin
            pg_r <= PG_RESET;
        end else if (CE && wr_pg) begin
            pg_r <= WDATA;
        end
    end

    // Peripheral enables, registered
    always_ff @(posedge MCLK) begin
        if (rst) begin
            BOD_ENABLE <= 1'b1;
            COMP_ENABLE <= 1'b0;
        end else if (CE) begin
            if (BOD_ALWAYS_ON) begin
                BOD_ENABLE <= 1'b1;
            end else if (state_nxt == ST_STOP) begin
                BOD_ENABLE <= 1'b0;
            end else begin
                BOD_ENABLE <= !pg_r[PG_BOD_BIT];
            end
            COMP_ENABLE <= !pg_r[PG_COMP_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Core clock and system reset request
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (rst) begin
            CORE_CLK_EN <= 1'b1;
            SYS_RESET_REQ <= 1'b0;
        end else if (CE) begin
            CORE_CLK_EN <= (state_nxt == ST_RUN);
            SYS_RESET_REQ <= (state_nxt == ST_RESET);
        end
    end

    // ----------------------------------------------------------------
    // Reset cause flags
    // ----------------------------------------------------------------
    // Hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (rst) begin
            cause_r <= '0;
        end else if (CE) begin
            if (rec_done) begin
                cause_r.stop <= 1'b1;
            end else if (WR && ADDR == CAUSE_ADDR && WDATA[0]) begin
                cause_r.stop <= 1'b0;
            end
            if (rec_done && wdt_wake_r) begin
                cause_r.wdt <= 1'b1;
            end else if (WR && ADDR == CAUSE_ADDR && WDATA[1]) begin
                cause_r.wdt <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control and enable registers
    // ----------------------------------------------------------------
    // Stop bit is a command and does not stay set
    always_ff @(posedge MCLK) begin
        if (rst) begin
            ctrl_r <= ZERO8;
            src_en_r <= '0;
            imask_r <= '0;
        end else if (CE) begin
            if (wr_ctrl) begin
                ctrl_r <= WDATA & ~(8'h01 << CTRL_STOP_BIT);
            end
            if (WR && ADDR == SRC_EN_ADDR) begin
                src_en_r <= WDATA;
            end
            if (WR && ADDR == IMASK_ADDR) begin
                imask_r <= WDATA[EV_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt events
    // ----------------------------------------------------------------
    always_comb begin
        ev_set = '0;
        ev_set[EV_REC_BIT] = rec_done;
        // Watchdog irq presented only after recovery, if irqs on
        ev_set[EV_WDT_BIT] = rec_done && wdt_wake_r &&
            ctrl_r[CTRL_WDT_IRQ_BIT] && ctrl_r[CTRL_IRQ_EN_BIT];
        // Short pulses gone by the capture raise nothing
        ev_set[EV_PIN_BIT] = rec_done && pin_persist;
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge MCLK) begin
        if (rst) begin
            istat_r <= '0;
        end else if (CE) begin
            if (WR && ADDR == ISTAT_ADDR) begin
                istat_r <= (istat_r & ~WDATA[EV_W-1:0]) | ev_set;
            end else begin
                istat_r <= istat_r | ev_set;
            end
        end
    end

    // Level interrupt from the next status value
    always_ff @(posedge MCLK) begin
        if (rst) begin
            IRQ <= 1'b0;
        end else if (CE) begin
            if (WR && ADDR == ISTAT_ADDR) begin
                IRQ <= |(((istat_r & ~WDATA[EV_W-1:0]) | ev_set)
                    & imask_r);
            end else if (WR && ADDR == IMASK_ADDR) begin
                IRQ <= |((istat_r | ev_set) & WDATA[EV_W-1:0]);
            end else begin
                IRQ <= |((istat_r | ev_set) & imask_r);
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Unmapped addresses read as zero
    always_ff @(posedge MCLK) begin
        if (rst) begin
            RDATA <= ZERO8;
        end else if (CE) begin
            if (!RD) begin
                RDATA <= ZERO8;
            end else if (ADDR == PG_ADDR) begin
                RDATA <= pg_r;
            end else if (ADDR == CAUSE_ADDR) begin
                RDATA <= cause_r;
            end else if (ADDR == CTRL_ADDR) begin
                RDATA <= ctrl_r;
            end else if (ADDR == SRC_EN_ADDR) begin
                RDATA <= src_en_r;
            end else if (ADDR == PORT_ADDR) begin
                RDATA <= port_q;
            end else if (ADDR == ISTAT_ADDR) begin
                RDATA <= {5'h00, istat_r};
            end else if (ADDR == IMASK_ADDR) begin
                RDATA <= {5'h00, imask_r};
            end else begin
                RDATA <= ZERO8;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_in_stop;
        CE && state_r == ST_STOP && !reset_src;
    endsequence

    sequence s_recover_end;
        CE && rec_done;
    endsequence

    a_wdt_wakes: assert property (@(posedge MCLK)
        disable iff (rst || !CE)
        s_in_stop ##0 WDT_TIMEOUT |=> state_r == ST_RECOVER ##0
        !CORE_CLK_EN)
        else $error("watchdog timeout did not start recovery");

    // Status bit must be clear on entry so its later rise is visible
    a_wdt_irq_later: assert property (@(posedge MCLK)
        disable iff (rst || !CE)
        s_in_stop ##0 WDT_TIMEOUT && !istat_r[EV_WDT_BIT] &&
        ctrl_r[CTRL_WDT_IRQ_BIT] && ctrl_r[CTRL_IRQ_EN_BIT] |=>
        !istat_r[EV_WDT_BIT] ##16 istat_r[EV_WDT_BIT])
        else $error("watchdog interrupt not after recovery");

    a_pin_wakes: assert property (@(posedge MCLK)
        disable iff (rst || !CE)
        s_in_stop ##0 !WDT_TIMEOUT && pin_change |=>
        state_r == ST_RECOVER)
        else $error("pin change did not start recovery");

    a_ext_reset: assert property (@(posedge MCLK)
        disable iff (rst || !CE)
        CE && state_r == ST_STOP && !EXT_RESET_N |=>
        SYS_RESET_REQ && state_r != ST_RECOVER)
        else $error("reset pin in stop did not reset");

    a_debug_reset: assert property (@(posedge MCLK)
        disable iff (rst || !CE)
        CE && state_r == ST_STOP && !DEBUG_N |=> SYS_RESET_REQ)
        else $error("debug pin low in stop did not reset");

    a_stop_flag: assert property (@(posedge MCLK)
        disable iff (rst || !CE)
        s_recover_end |=> cause_r.stop && CORE_CLK_EN)
        else $error("stop flag not set after recovery");

    a_wdt_flag: assert property (@(posedge MCLK)
        disable iff (rst || !CE)
        s_in_stop ##0 WDT_TIMEOUT |=> ##16 cause_r.wdt &&
        cause_r.stop)
        else $error("watchdog flags not set after recovery");

    a_latch_frozen: assert property (@(posedge MCLK)
        disable iff (rst || !CE)
        CE && state_r == ST_STOP |=> $stable(port_q))
        else $error("port latch sampled during stop");

    a_bod_stop: assert property (@(posedge MCLK)
        disable iff (rst || !CE)
        CE && state_r == ST_STOP && !BOD_ALWAYS_ON |-> !BOD_ENABLE)
        else $error("brown-out detector on in stop");

    // Enable lags the gate bit by one register stage
    a_comp_gate: assert property (@(posedge MCLK)
        disable iff (rst || !CE)
        CE && $stable(pg_r) |=>
        COMP_ENABLE == !$past(pg_r[PG_COMP_BIT]))
        else $error("comparator enable disagrees with gate bit");

    a_gate_kept: assert property (@(posedge MCLK)
        disable iff (POR_RST)
        SYS_RST && !WR |=> pg_r == $past(pg_r))
        else $error("power-gate changed on system reset");

    a_gate_reset: assert property (@(posedge MCLK)
        POR_RST |=> pg_r == PG_RESET)
        else $error("power-gate reset value wrong");

    a_clk_halted: assert property (@(posedge MCLK)
        disable iff (rst || !CE)
        s_in_stop ##0 !WDT_TIMEOUT && !pin_change |=>
        state_r == ST_STOP && !CORE_CLK_EN)
        else $error("left stop without a source");

endmodule

// ===== verif/far_side.sv
// Purpose: Watchdog, port pin and reset pin model at the far side.
// Assumes: Bench commands change just after MCLK rises.
// Notes:   A timeout is one pulse per toggle of the request.
module far_side
    import stop_pkg::*;
(
    input wire logic clk,
    input wire logic wdt_req,
    input wire logic [PORT_W-1:0] pin_lvl,
    input wire logic rst_low,
    input wire logic dbg_low,
    output logic wdt_pulse,
    output logic [PORT_W-1:0] pins,
    output logic ext_n,
    output logic dbg_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic req_q = 1'b0; // Last request level
    // One registered stage, like the real sources
    always_ff @(posedge clk) begin
        req_q <= wdt_req;
        wdt_pulse <= wdt_req ^ req_q;
        pins <= pin_lvl;
        ext_n <= ~rst_low;
        dbg_n <= ~dbg_low;
    end
endmodule

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the stop-mode power control.
// Assumes: Fixed seed; bus driven right after MCLK rises.
// Notes:   Outputs are sampled on the falling edge.
module testbench
    import stop_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 0, sys_rst = 1, por_rst = 1, wr = 0, rd = 0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00, pg, v, pin_lvl = 8'h00, b;
    logic wdt_req = 0, rst_low = 0, dbg_low = 0, bod_on = 0, ce = 1;
    logic [7:0] rdata, gpio;
    logic wdt, ext_n, dbg_n, clk_en, rst_req, bod_en, comp_en, irq;
    int err_total = 0, comparisons = 0, i, k;
    far_side u_far_side (.clk(mclk), .wdt_req(wdt_req),
        .pin_lvl(pin_lvl), .rst_low(rst_low), .dbg_low(dbg_low),
        .wdt_pulse(wdt), .pins(gpio), .ext_n(ext_n), .dbg_n(dbg_n));
    stop_power_ctrl u_stop_power_ctrl (.MCLK(mclk), .SYS_RST(sys_rst),
        .POR_RST(por_rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .WDT_TIMEOUT(wdt),
        .EXT_RESET_N(ext_n), .DEBUG_N(dbg_n), .GPIO_IN(gpio),
        .BOD_ALWAYS_ON(bod_on), .CORE_CLK_EN(clk_en),
        .SYS_RESET_REQ(rst_req), .BOD_ENABLE(bod_en),
        .COMP_ENABLE(comp_en), .IRQ(irq));
    // ----
    // Clock, bus tasks and checks
    // ----
    initial begin
        forever #2 mclk = ~mclk;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Brown-out enable: option forces on, else gate bit 4 low
    function automatic logic [7:0] bod_exp(input logic on,
        input logic [7:0] g);
        return 8'(on || !g[PG_BOD_BIT]);
    endfunction
    task wrb(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge mclk);
        wr <= 0;
    endtask
    task rdb(input logic [11:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1;
        @(posedge mclk);
        rd <= 0;
        @(negedge mclk);
        chk(rdata, exp);
        @(negedge mclk);
        chk(rdata, 8'h00);
    endtask
    task sysrst;
        @(posedge mclk);
        sys_rst <= 1;
        @(posedge mclk);
        sys_rst <= 0;
    endtask
    // Enter STOP and see it hold with no source
    task stop(input logic [7:0] c);
        wrb(CTRL_ADDR, c);
        repeat (6) @(negedge mclk);
        chk(8'(clk_en), 8'h00);
        chk(8'(bod_en), 8'h00);
    endtask
    task wait_run;
        repeat (40) if (clk_en !== 1'b1) @(negedge mclk);
        chk(8'(clk_en), 8'h01);
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ----
    // Test sequence
    // ----
    initial begin
        void'($urandom(32'h4A48));
        repeat (3) @(posedge mclk);
        sys_rst <= 0;
        por_rst <= 0;
        rdb(PG_ADDR, PG_RESET);
        rdb(12'hF8F, 8'h00);
        for (i = 0; i < 6; i++) begin
            pg = 8'($urandom) & 8'h12;
            bod_on <= i[0];
            wrb(PG_ADDR, pg);
            rdb(PG_ADDR, pg);
            chk(8'(comp_en), 8'(!pg[PG_COMP_BIT]));
            chk(8'(bod_en), bod_exp(i[0], pg));
        end
        bod_on <= 0;
        sysrst();
        rdb(PG_ADDR, pg);
        // Clock enable low must swallow a write
        ce <= 0;
        wrb(PG_ADDR, ~pg);
        ce <= 1;
        rdb(PG_ADDR, pg);
        $display("power gate test done");
        wrb(IMASK_ADDR, 8'h02);
        rdb(IMASK_ADDR, 8'h02);
        for (k = 0; k < 3; k++) begin
            v = (k == 0) ? 8'h01 : ((k == 1) ? 8'h07 : 8'h03);
            stop(v);
            @(posedge mclk);
            wdt_req <= ~wdt_req;
            wait_run();
            rdb(CAUSE_ADDR, 8'h03);
            rdb(CTRL_ADDR, v & 8'hFE);
            chk(8'(irq), 8'((v == 8'h07) ? 1 : 0));
            wrb(CAUSE_ADDR, 8'h03);
            wrb(ISTAT_ADDR, 8'h07);
            rdb(CAUSE_ADDR, 8'h00);
            chk(8'(irq), 8'h00);
        end
        $display("watchdog test done");
        wrb(SRC_EN_ADDR, 8'hFF);
        rdb(SRC_EN_ADDR, 8'hFF);
        b = 8'h01 << ($urandom % 8);
        for (k = 0; k < 2; k++) begin
            v = pin_lvl ^ b;
            stop(8'h01);
            @(posedge mclk);
            pin_lvl <= v;
            wait_run();
            rdb(PORT_ADDR, v);
            rdb(CAUSE_ADDR, 8'h01);
            wrb(CAUSE_ADDR, 8'h03);
        end
        wrb(ISTAT_ADDR, 8'h07);
        stop(8'h01);
        @(posedge mclk);
        pin_lvl <= v ^ 8'h80;
        @(posedge mclk);
        @(posedge mclk);
        pin_lvl <= v;
        wait_run();
        rdb(PORT_ADDR, v);
        rdb(ISTAT_ADDR, 8'h01);
        $display("pin test done");
        for (k = 0; k < 2; k++) begin
            stop(8'h01);
            @(posedge mclk);
            rst_low <= (k == 0);
            dbg_low <= (k == 1);
            repeat (4) @(negedge mclk);
            chk(8'(rst_req), 8'h01);
            chk(8'(clk_en), 8'h00);
            @(posedge mclk);
            rst_low <= 0;
            dbg_low <= 0;
            sysrst();
            @(negedge mclk);
            chk(8'(rst_req), 8'h00);
        end
        $display("reset source test done");
        summarize();
    end
    initial begin
        #40000;
        err_total++;
        summarize();
    end
endmodule
